// *** inc/pidsr_cfg.svh ***
// Offsets, field positions, reset values and codes of the primary ID/status pair.
// Assumes a 32-bit APB master; each 16-bit register takes one aligned word.
//
// Functional notes
// - ID upper bits hold fixed version code.
// - ID bits three and two read zero.
// - Bit one flags last frame rejected.
// - Bit zero is device generated parity.
// - Status bit eleven ORs fault register.
// - Status bits 15:12 and 10 zero.
// - Status 9:8 echo latest turn-on level.
// - Status bit seven set in run mode.
// - Status bit six mirrors remote readiness.
// - Status 5:2 echo latest turn-off level.
// - Status word reads 0x087d after reset.
// - Each offset selects one whole register.
// - Hardware fields are read-only to software.
`ifndef PIDSR_CFG_SVH
`define PIDSR_CFG_SVH

`define PIDSR_IDX_ID 8'h00
`define PIDSR_IDX_STAT 8'h01
`define PIDSR_VER_LSB 4
`define PIDSR_ERR_BIT 11
`define PIDSR_ON_LSB 8
`define PIDSR_RUN_BIT 7
`define PIDSR_REMOTE_OK_BIT 6
`define PIDSR_OFF_LSB 2
`define PIDSR_REJECT_BIT 1
`define PIDSR_PAR_BIT 0
`define PIDSR_STAT_RESET 16'h087d
`define PIDSR_ON_RESET 2'h0
`define PIDSR_OFF_RESET 4'hf
`define PIDSR_ERR_RESET 1'h1
`define PIDSR_REMOTE_OK_RESET 1'h1
`define PIDSR_RUN_RESET 1'h0
`define PIDSR_REJECT_RESET 1'h0
`define PIDSR_RUN_MODE 3'h4

`endif

// *** inc/pidsr_pkg.sv ***
// Types shared by the primary ID/status register block.
// Assumes the constants header is included by each user.
package pidsr_pkg;

   // Events from the serial frame engine and mode logic
   typedef struct packed
   {
      logic frame_done;
      logic last_frame_rejected;
      logic on_valid;
      logic [1:0] turn_on_level_request;
      logic off_valid;
      logic [3:0] soft_turn_off;
   } pidsr_link_t;

   // Held status fields feeding the word builder
   typedef struct packed
   {
      logic err;
      logic [1:0] turn_on_level_echo;
      logic running_state_flag;
      logic remote_side_ok;
      logic [3:0] turn_off_level_echo;
      logic last_frame_rejected;
   } pidsr_stat_t;

   typedef enum logic [1:0]
   {
      PIDSR_IDLE = 2'b00,
      PIDSR_ANSWER = 2'b01
   } pidsr_apb_state_t;

endpackage

// *** rtl/pidsr_echo_hold.sv ***
// Holds echoed levels, frame verdict and sampled status inputs.
// Assumes inputs are synchronous to pclk.
`timescale 1ns/1ps
`include "pidsr_cfg.svh"
module pidsr_echo_hold
(
   input wire logic pclk,
   input wire logic presetn,
   input wire pidsr_pkg::pidsr_link_t link,
   input wire logic [15:0] fault_register,
   input wire logic [2:0] op_mode,
   input wire logic remote_side_ok,
   output pidsr_pkg::pidsr_stat_t stat_q
);

   pidsr_pkg::pidsr_stat_t stat_d;

   always_comb
   begin
      stat_d = stat_q;
      stat_d.err = |fault_register;
      stat_d.running_state_flag = (op_mode == `PIDSR_RUN_MODE);
      stat_d.remote_side_ok = remote_side_ok;
      if (link.on_valid)
      begin
         stat_d.turn_on_level_echo = link.turn_on_level_request;
      end
      if (link.off_valid)
      begin
         stat_d.turn_off_level_echo = link.soft_turn_off;
      end
      if (link.frame_done)
      begin
         stat_d.last_frame_rejected = link.last_frame_rejected;
      end
   end

   // Reset values chosen so the status word reads its documented reset pattern
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stat_q <= '{err: `PIDSR_ERR_RESET, turn_on_level_echo: `PIDSR_ON_RESET,
                     running_state_flag: `PIDSR_RUN_RESET,
                     remote_side_ok: `PIDSR_REMOTE_OK_RESET,
                     turn_off_level_echo: `PIDSR_OFF_RESET,
                     last_frame_rejected: `PIDSR_REJECT_RESET};
      end
      else
      begin
         stat_q <= stat_d;
      end
   end

endmodule

// *** rtl/pidsr_regs.sv ***
// APB slave presenting the primary identification and status words.
// Assumes an APB master on pclk; all register contents are read-only.
`timescale 1ns/1ps
`include "pidsr_cfg.svh"
module pidsr_regs
#(
   parameter int AW = 8,
   parameter logic [11:0] VERSION = 12'h5c1 // Arbitrary neutral value
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pidsr_pkg::pidsr_link_t link,
   input wire logic [15:0] fault_register,
   input wire logic [2:0] op_mode,
   input wire logic remote_side_ok,
   output logic [15:0] side_a_state_reg
);

   // Below three bits the two word addresses would alias
   if (AW < 3)
   begin : g_aw_check
      $error("pidsr_regs: AW too small for the register map");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Held state and word assembly

   pidsr_pkg::pidsr_stat_t stat_q;
   logic [15:0] chip_identity_reg;
   logic [15:0] stat_word;
   wire pidsr_pkg::pidsr_stat_t stat;

   pidsr_echo_hold u_hold
   (
      .pclk(pclk),
      .presetn(presetn),
      .link(link),
      .fault_register(fault_register),
      .op_mode(op_mode),
      .remote_side_ok(remote_side_ok),
      .stat_q(stat_q)
   );

   pidsr_word_build #(.VERSION(VERSION)) u_build
   (
      .pclk(pclk),
      .presetn(presetn),
      .stat(stat),
      .id_word_q(chip_identity_reg),
      .stat_word_q(stat_word)
   );

   assign stat = stat_q;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   // Printed offsets are word indices; the byte address is four times that
   function automatic logic [AW-1:0] addr_of(input logic [7:0] idx);
      logic [AW+9:0] a;
      a = {{AW{1'b0}}, idx, 2'b00};
      return a[AW-1:0];
   endfunction

   pidsr_pkg::pidsr_apb_state_t state_q;
   pidsr_pkg::pidsr_apb_state_t state_d;
   logic [31:0] prdata_d;
   logic pslverr_d;

   wire logic setup_phase;
   wire logic hit_id;
   wire logic hit_stat;
   wire logic hit_any;

   assign setup_phase = psel && !penable;
   assign hit_id = (paddr == addr_of(`PIDSR_IDX_ID));
   assign hit_stat = (paddr == addr_of(`PIDSR_IDX_STAT));

   assign hit_any = hit_id || hit_stat;

   // Writes to the two mapped offsets are accepted but change nothing; unmapped ones get pslverr like reads
   always_comb
   begin
      state_d = pidsr_pkg::PIDSR_IDLE;
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      case (state_q)
         pidsr_pkg::PIDSR_IDLE:
         begin
            if (setup_phase)
            begin
               state_d = pidsr_pkg::PIDSR_ANSWER;
               pslverr_d = !hit_any;
               if (!pwrite && hit_id)
               begin
                  prdata_d = {16'h0000, chip_identity_reg};
               end
               else if (!pwrite && hit_stat)
               begin
                  prdata_d = {16'h0000, stat_word};
               end
            end
         end
         pidsr_pkg::PIDSR_ANSWER:
         begin
            state_d = pidsr_pkg::PIDSR_IDLE;
         end
         default:
         begin
            state_d = pidsr_pkg::PIDSR_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= pidsr_pkg::PIDSR_IDLE;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         side_a_state_reg <= `PIDSR_STAT_RESET;
      end
      else
      begin
         state_q <= state_d;
         prdata <= prdata_d;
         pready <= (state_d == pidsr_pkg::PIDSR_ANSWER);
         pslverr <= pslverr_d;
         side_a_state_reg <= stat_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic after_reset_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         after_reset_q <= 1'b0;
      end
      else
      begin
         after_reset_q <= 1'b1;
      end
   end

   // Completed reads only; refused ones carry no word
   wire logic rd_done;
   assign rd_done = psel && penable && pready && !pwrite && !pslverr;

   sequence s_id_read;
      psel && !penable && !pwrite && hit_id;
   endsequence

   sequence s_stat_read;
      psel && !penable && !pwrite && hit_stat;
   endsequence

   property p_id_version;
      @(posedge pclk) disable iff (!presetn)
      s_id_read ##1 (penable && psel) |-> prdata[15:4] == VERSION;
   endproperty
   a_id_version: assert property (p_id_version) else $error("version field wrong");

   property p_id_zero;
      @(posedge pclk) disable iff (!presetn)
      s_id_read |=> prdata[3:2] == 2'b00 && prdata[31:16] == 16'h0000;
   endproperty
   a_id_zero: assert property (p_id_zero) else $error("id zero bits set");

   property p_rejected;
      @(posedge pclk) disable iff (!presetn)
      link.frame_done |-> ##2 stat_word[`PIDSR_REJECT_BIT] == $past(link.last_frame_rejected, 2);
   endproperty
   a_rejected: assert property (p_rejected) else $error("rejected flag not reported");

   property p_parity;
      @(posedge pclk) disable iff (!presetn)
      rd_done |-> ^prdata[15:0] == 1'b1;
   endproperty
   a_parity: assert property (p_parity) else $error("read word parity not odd");

   property p_err;
      @(posedge pclk) disable iff (!presetn)
      after_reset_q |-> ##2 stat_word[`PIDSR_ERR_BIT] == |$past(fault_register, 2);
   endproperty
   a_err: assert property (p_err) else $error("error summary wrong");

   property p_resv;
      @(posedge pclk) disable iff (!presetn)
      s_stat_read |=> prdata[15:12] == 4'h0 && prdata[10] == 1'b0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved status bits set");

   property p_on_echo;
      @(posedge pclk) disable iff (!presetn)
      link.on_valid |-> ##2 stat_word[9:8] == $past(link.turn_on_level_request, 2);
   endproperty
   a_on_echo: assert property (p_on_echo) else $error("turn-on echo wrong");

   property p_run_flag;
      @(posedge pclk) disable iff (!presetn)
      after_reset_q |-> ##2 stat_word[`PIDSR_RUN_BIT] == ($past(op_mode, 2) == `PIDSR_RUN_MODE);
   endproperty
   a_run_flag: assert property (p_run_flag) else $error("active flag wrong");

   property p_remote_ok;
      @(posedge pclk) disable iff (!presetn)
      after_reset_q |-> ##2 stat_word[`PIDSR_REMOTE_OK_BIT] == $past(remote_side_ok, 2);
   endproperty
   a_remote_ok: assert property (p_remote_ok) else $error("remote ready wrong");

   property p_off_echo;
      @(posedge pclk) disable iff (!presetn)
      link.off_valid |-> ##2 stat_word[5:2] == $past(link.soft_turn_off, 2);
   endproperty
   a_off_echo: assert property (p_off_echo) else $error("turn-off echo wrong");

   property p_reset;
      @(posedge pclk) disable iff (!presetn)
      !after_reset_q |-> stat_word == `PIDSR_STAT_RESET && side_a_state_reg == `PIDSR_STAT_RESET;
   endproperty
   a_reset: assert property (p_reset) else $error("status reset value wrong");

   property p_map;
      @(posedge pclk) disable iff (!presetn)
      s_stat_read |=> prdata[15:0] == $past(stat_word) && !pslverr && pready;
   endproperty
   a_map: assert property (p_map) else $error("status offset decode wrong");

   property p_ro;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && pwrite && hit_id |=> ##1 chip_identity_reg[15:2] == {VERSION, 2'b00};
   endproperty
   a_ro: assert property (p_ro) else $error("write altered id word");

   property p_whole_odd;
      @(posedge pclk) disable iff (!presetn)
      after_reset_q |-> ^stat_word && ^chip_identity_reg;
   endproperty
   a_whole_odd: assert property (p_whole_odd) else $error("held word parity even");

   property p_id_map;
      @(posedge pclk) disable iff (!presetn)
      s_id_read |=> prdata[15:0] == $past(chip_identity_reg) && !pslverr && pready;
   endproperty
   a_id_map: assert property (p_id_map) else $error("id offset decode wrong");

   property p_unmapped;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !hit_any |=> pready && pslverr && prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");

   property p_write_quiet;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && pwrite |=> pready && prdata == 32'h0000_0000;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("write returned data");

   property p_id_rejected;
      @(posedge pclk) disable iff (!presetn)
      link.frame_done |-> ##2
         chip_identity_reg[`PIDSR_REJECT_BIT] == $past(link.last_frame_rejected, 2);
   endproperty
   a_id_rejected: assert property (p_id_rejected) else $error("id flag wrong");

   // Echoes change only on a request, never on stray values between frames
   property p_on_keep;
      @(posedge pclk) disable iff (!presetn)
      after_reset_q && !link.on_valid |-> ##2 stat_word[9:8] == $past(stat_word[9:8]);
   endproperty
   a_on_keep: assert property (p_on_keep) else $error("turn-on echo moved");

   property p_off_keep;
      @(posedge pclk) disable iff (!presetn)
      after_reset_q && !link.off_valid |-> ##2 stat_word[5:2] == $past(stat_word[5:2]);
   endproperty
   a_off_keep: assert property (p_off_keep) else $error("turn-off echo moved");

   property p_mirror;
      @(posedge pclk) disable iff (!presetn)
      after_reset_q |-> side_a_state_reg == $past(stat_word);
   endproperty
   a_mirror: assert property (p_mirror) else $error("status output copy wrong");

endmodule

// *** rtl/pidsr_word_build.sv ***
// Assembles the identification and status words with odd parity.
// Assumes held fields arrive from flip-flops in the same clock domain.
`timescale 1ns/1ps
`include "pidsr_cfg.svh"
module pidsr_word_build
#(
   parameter logic [11:0] VERSION = 12'h5c1 // Arbitrary neutral value
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire pidsr_pkg::pidsr_stat_t stat,
   output logic [15:0] id_word_q,
   output logic [15:0] stat_word_q
);

   // Odd parity: bit zero makes the whole word hold an odd count of ones
   function automatic logic [15:0] add_parity(input logic [15:0] w);
      logic [15:0] r;
      r = w;
      r[`PIDSR_PAR_BIT] = ~(^w[15:1]);
      return r;
   endfunction

   localparam logic [15:0] ID_RESET = add_parity({VERSION, 4'h0});

   wire logic [15:0] id_raw;
   wire logic [15:0] stat_raw;

   assign id_raw = {VERSION, 2'h0, stat.last_frame_rejected, 1'h0};
   assign stat_raw = {4'h0, stat.err, 1'h0, stat.turn_on_level_echo,
                      stat.running_state_flag, stat.remote_side_ok,
                      stat.turn_off_level_echo, stat.last_frame_rejected, 1'h0};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         id_word_q <= ID_RESET;
         stat_word_q <= `PIDSR_STAT_RESET;
      end
      else
      begin
         id_word_q <= add_parity(id_raw);
         stat_word_q <= add_parity(stat_raw);
      end
   end

endmodule

// *** tb/pidsr_host.sv ***
// Host controller model: an APB master for the register block.
// Assumes a slave on the same pclk; it waits for pready with no fixed count.
`timescale 1ns/1ps
module pidsr_host
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Released lines are inverted so a stale address or data cannot pass for a match
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      paddr <= ~a;
      pwdata <= ~wd;
   endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the primary identification and status words.
// Assumes the host model as APB master; the bench drives all status sources.
`timescale 1ns/1ps
module tb_top;
   localparam logic [11:0] VER = 12'h3b6; // Arbitrary value
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, remote_side_ok, e, rej_flag;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [15:0] fault_register, side_a_state_reg;
   logic [2:0] op_mode;
   pidsr_pkg::pidsr_link_t link;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////////////
   pidsr_regs #(.AW(8), .VERSION(VER)) DUT
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link(link), .fault_register(fault_register), .op_mode(op_mode),
      .remote_side_ok(remote_side_ok), .side_a_state_reg(side_a_state_reg)
   );
   pidsr_host host
   (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );
   initial
   begin
      pclk = 1'h0;
      forever #12.5 pclk = ~pclk;
   end
   // Whole run needs about 250 cycles; the ceiling leaves a wide margin
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         failures++;
         print_verdict;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s exp %h seen %h", n, exp, seen);
      end
   endtask
   // Word with odd parity over all sixteen bits
   function automatic logic [15:0] ws(input logic [15:1] w);
      return {w, ~(^w)};
   endfunction
   // Echo requests come with one-cycle valid pulses; the next cycle flips the values
   task automatic apply(input logic [1:0] on, input logic [3:0] off, input logic rej,
      input logic [15:0] f, input logic [2:0] m, input logic r);
      @(posedge pclk);
      link <= {1'h1, rej, 1'h1, on, 1'h1, off};
      fault_register <= f;
      op_mode <= m;
      remote_side_ok <= r;
      @(posedge pclk);
      link <= {1'h0, ~rej, 1'h0, ~on, 1'h0, ~off};
      repeat (3) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      check("side_a_state_reg", {16'h0, side_a_state_reg}, 32'h087d);
      host.xfer(1'h0, 8'h04, 32'h0, d, e);
      check("status", d, 32'h087d);
      host.xfer(1'h0, 8'h00, 32'h0, d, e);
      check("id", d, {16'h0, ws({VER, 2'h0, 1'h0})});
      check("id_parity", {31'h0, ^d}, 32'h1);
      $display("t_reset done");
   endtask
   task automatic t_write;
      host.xfer(1'h1, 8'h00, 32'hffffffff, d, e);
      check("wr_err", {31'h0, e}, 32'h0);
      host.xfer(1'h1, 8'h04, 32'h0, d, e);
      host.xfer(1'h0, 8'h00, 32'h0, d, e);
      check("id_after_wr", d, {16'h0, ws({VER, 2'h0, 1'h0})});
      host.xfer(1'h0, 8'h04, 32'h0, d, e);
      check("stat_after_wr", d, 32'h087d);
      $display("t_write done");
   endtask
   task automatic t_unmapped;
      logic [7:0] a[3] = '{8'h08, 8'h0c, 8'hfc};
      for (int i = 0; i < 6; i++)
      begin
         host.xfer(i[0], a[i/2], 32'h5a5a5a5a, d, e);
         check("unmapped_err", {31'h0, e}, 32'h1);
         check("unmapped_data", d, 32'h0);
      end
      $display("t_unmapped done");
   endtask
   task automatic t_fields;
      logic [15:0] f;
      logic [15:0] x;
      for (int i = 0; i < 16; i++)
      begin
         f = (i % 3 == 0) ? 16'h0 : 16'h1 << i;
         rej_flag = i[0];
         apply(i[1:0], i[3:0] ^ 4'h5, rej_flag, f, i[2:0], i[1]);
         x = ws({4'h0, |f, 1'h0, i[1:0], (i[2:0] == 3'h4), i[1], i[3:0] ^ 4'h5, rej_flag});
         host.xfer(1'h0, 8'h04, 32'h0, d, e);
         check("status", d, {16'h0, x});
         check("side_a_state_reg", {16'h0, side_a_state_reg}, {16'h0, x});
         host.xfer(1'h0, 8'h00, 32'h0, d, e);
         check("id", d, {16'h0, ws({VER, 2'h0, rej_flag})});
      end
      $display("t_fields done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      presetn = 1'h0;
      link = '0;
      fault_register = 16'h0001;
      op_mode = 3'h0;
      remote_side_ok = 1'h1;
      rej_flag = 1'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      t_reset;
      t_write;
      t_unmapped;
      t_fields;
      // Inputs back to reset-time levels, then a reset in mid-run
      apply(2'h0, 4'hf, 1'h0, 16'h0001, 3'h0, 1'h1);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      t_reset;
      print_verdict;
   end
endmodule
